/* File: verilog/msg_hdr_pkg.sv */
// package: message buffer header word layout and register map
package msg_hdr_pkg;
  localparam int unsigned NUM_BUFS     = 32;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ADDR_W       = 7;
  // word index inside one buffer; bus address = buf * 4 + word
  localparam logic [1:0] WORD_BASE_ID  = 2'h0;
  localparam logic [1:0] WORD_EXT_ID   = 2'h1;
  localparam logic [1:0] WORD_LEN_CTL  = 2'h2;
  // base identifier word fields
  localparam int unsigned BASE_ID_MSB  = 12;
  localparam int unsigned BASE_ID_LSB  = 2;
  localparam int unsigned SUB_RR_POS   = 1;
  localparam int unsigned EXT_FMT_POS  = 0;
  localparam logic [15:0] BASE_MASK    = 16'h1fff;
  // extension identifier word: ext bits 17..6 in 11..0
  localparam logic [15:0] EXT_MASK     = 16'h0fff;
  // length control word: ext 5..0 in 15..10, rtr 9, reserved 8..4
  localparam int unsigned LEN_EXT_LSB  = 10;
  localparam int unsigned RTR_POS      = 9;
  localparam int unsigned RSV_HI_POS   = 8;
  localparam int unsigned RSV_LO_POS   = 4;
  localparam logic [15:0] LEN_MASK     = 16'hfe0f;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  typedef struct packed {
    logic [10:0] base_id;
    logic        sub_rr;
    logic        ext_fmt;
    logic [17:0] ext_id;
    logic        rtr;
    logic [3:0]  dlc;
  } hdr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;
endpackage : msg_hdr_pkg

/* File: verilog/msg_hdr_store.sv */
// module: header words of 32 message buffers with field packing
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RL1] base identifier sits in bits 12..2
// [RL2] bit 1 flags substitute remote request
// [RL3] bit 0 selects extended identifier format
// [RL4] unused upper bits always read zero
// [RL5] extension bits 17..6 in second word
// [RL6] third word: ext low, rtr, reserved, length
module msg_hdr_store (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire msg_hdr_pkg::bus_req_t         bus,
  output logic [31:0]                        rdata,
  // controller side: load and fetch one decoded header
  input  wire logic                          ctl_wr,
  input  wire logic [4:0]                    ctl_buf,
  input  wire msg_hdr_pkg::hdr_t             ctl_hdr,
  output var msg_hdr_pkg::hdr_t              ctl_hdr_out
);
  import msg_hdr_pkg::*;

  // all state in one struct: three words per buffer and the read data
  typedef struct packed {
    logic [NUM_BUFS-1:0][2:0][WORD_W-1:0] words;
    logic [31:0]                          rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [4:0]        bus_buf;
  logic [1:0]        bus_word;
  logic              bus_hit;
  logic [WORD_W-1:0] cur;
  logic [WORD_W-1:0] w0;
  logic [WORD_W-1:0] w1;
  logic [WORD_W-1:0] w2;

  // bus address: buffer number above, word slot in the low two bits
  assign bus_buf  = bus.addr[6:2];
  assign bus_word = bus.addr[1:0];
  assign bus_hit  = (bus_word != 2'h3);

  // pack a decoded header into three words
  // all three come from one header, so a load never leaves a buffer
  // half old and half new
  always_comb begin
    // [RL1] base id field
    w0 = {3'h0, ctl_hdr.base_id, 2'h0};
    // [RL2] remote request flag
    w0[SUB_RR_POS] = ctl_hdr.sub_rr;
    // [RL3] format select
    w0[EXT_FMT_POS] = ctl_hdr.ext_fmt;
    // [RL5] upper extension bits
    w1 = {4'h0, ctl_hdr.ext_id[17:6]};
    // [RL6] low extension, rtr, reserved zero, length
    w2 = {ctl_hdr.ext_id[5:0], ctl_hdr.rtr, 5'h00, ctl_hdr.dlc};
  end

  // next state: software writes first, controller load wins same buffer
  always_comb begin
    st_d = st_q;
    cur  = st_q.words[bus_buf][(bus_word == 2'h3) ? 2'h0 : bus_word];
    st_d.rdata = UNMAPPED_RD;
    if (bus.wr && bus_hit) begin
      // [RL4] masking keeps unused bits zero; [RL6] reserved forced zero
      case (bus_word)
        WORD_BASE_ID: st_d.words[bus_buf][0] = bus.wdata[15:0] & BASE_MASK;
        WORD_EXT_ID:  st_d.words[bus_buf][1] = bus.wdata[15:0] & EXT_MASK;
        WORD_LEN_CTL: st_d.words[bus_buf][2] = bus.wdata[15:0] & LEN_MASK;
        default:      st_d.words[bus_buf][0] = st_q.words[bus_buf][0];
      endcase
    end
    // load last: it overrides a bus write to the same buffer
    if (ctl_wr) begin
      st_d.words[ctl_buf][0] = w0;
      st_d.words[ctl_buf][1] = w1;
      st_d.words[ctl_buf][2] = w2;
    end
    // read data valid the cycle after the strobe
    if (bus.rd && bus_hit) begin
      st_d.rdata = {16'h0000, cur};
    end
  end

  // one register stage; reset clears every word, so a never loaded
  // buffer reads as an empty standard frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // read data straight from its flop; zero in every idle cycle
  assign rdata = st_q.rdata;

  // unpack stored words for the controller
  // follows ctl_buf in the same cycle, with no register stage
  always_comb begin
    ctl_hdr_out.base_id = st_q.words[ctl_buf][0][BASE_ID_MSB:BASE_ID_LSB];
    ctl_hdr_out.sub_rr  = st_q.words[ctl_buf][0][SUB_RR_POS];
    ctl_hdr_out.ext_fmt = st_q.words[ctl_buf][0][EXT_FMT_POS];
    ctl_hdr_out.ext_id  = {st_q.words[ctl_buf][1][11:0],
                           st_q.words[ctl_buf][2][15:LEN_EXT_LSB]};
    ctl_hdr_out.rtr     = st_q.words[ctl_buf][2][RTR_POS];
    ctl_hdr_out.dlc     = st_q.words[ctl_buf][2][3:0];
  end

  // read side: rdata carries only the word addressed one cycle before,
  // and every bit with no storage behind it reads back as zero

  // [RL4] base word top zero
  a_upper_zero: assert property (@(posedge clk) disable iff (rst) // [RL4]
    bus.rd && bus_word == WORD_BASE_ID |=> rdata[15:13] == 3'h0)
    else $error("base word upper bits not zero");

  // [RL4] ext word top zero
  a_ext_zero: assert property (@(posedge clk) disable iff (rst) // [RL4]
    bus.rd && bus_word == WORD_EXT_ID |=> rdata[15:12] == 4'h0)
    else $error("ext word upper bits not zero");

  // [RL6] reserved bits read zero
  a_rsv_zero: assert property (@(posedge clk) disable iff (rst) // [RL6]
    bus.rd && bus_word == WORD_LEN_CTL |=> rdata[8:4] == 5'h00)
    else $error("reserved bits not zero");

  // [RL4] upper half unused
  a_hi_half: assert property (@(posedge clk) disable iff (rst) // [RL4]
    bus.rd |=> rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // [RL4] unmapped slot reads zero
  a_gap_zero: assert property (@(posedge clk) disable iff (rst) // [RL4]
    bus.rd && !bus_hit |=> rdata == UNMAPPED_RD)
    else $error("unmapped word read not zero");

  // [RL4] no read, no data
  // a lingering word would look like a second answer to a poll
  a_idle_zero: assert property (@(posedge clk) disable iff (rst) // [RL4]
    !bus.rd |=> rdata == UNMAPPED_RD)
    else $error("read data held past its cycle");

  // software writes keep the written value with every unused bit
  // cleared; a load to the same buffer in that cycle overrides the
  // write, so such cycles are left to the load checks below

  // [RL1] base word kept masked
  a_base_write: assert property (@(posedge clk) disable iff (rst) // [RL1]
    bus.wr && bus_word == WORD_BASE_ID && !(ctl_wr && ctl_buf == bus_buf)
    |=> st_q.words[$past(bus_buf)][0] == {3'h0, $past(bus.wdata[12:0])})
    else $error("base word write not kept");

  // [RL5] ext word kept masked
  a_ext_write: assert property (@(posedge clk) disable iff (rst) // [RL5]
    bus.wr && bus_word == WORD_EXT_ID && !(ctl_wr && ctl_buf == bus_buf)
    |=> st_q.words[$past(bus_buf)][1] == {4'h0, $past(bus.wdata[11:0])})
    else $error("ext word write not kept");

  // [RL6] reserved cleared on write
  a_len_write: assert property (@(posedge clk) disable iff (rst) // [RL6]
    bus.wr && bus_word == WORD_LEN_CTL && !(ctl_wr && ctl_buf == bus_buf)
    |=> st_q.words[$past(bus_buf)][2] ==
        {$past(bus.wdata[15:9]), 5'h00, $past(bus.wdata[3:0])})
    else $error("length word write not kept");

  // [RL4] unmapped slot takes nothing
  a_gap_write: assert property (@(posedge clk) disable iff (rst) // [RL4]
    bus.wr && !bus_hit && !(ctl_wr && ctl_buf == bus_buf)
    |=> st_q.words[$past(bus_buf)] == $past(st_q.words[bus_buf]))
    else $error("unmapped word write changed a buffer");

  // a controller load places the whole header in one pulse, whatever
  // the bus does to the same buffer in that cycle

  // [RL1] base id placement
  a_base_pack: assert property (@(posedge clk) disable iff (rst) // [RL1]
    ctl_wr |=> st_q.words[$past(ctl_buf)][0][BASE_ID_MSB:BASE_ID_LSB]
               == $past(ctl_hdr.base_id))
    else $error("base id misplaced");

  // [RL2] remote flag placement
  a_srr_pack: assert property (@(posedge clk) disable iff (rst) // [RL2]
    ctl_wr |=> st_q.words[$past(ctl_buf)][0][SUB_RR_POS]
               == $past(ctl_hdr.sub_rr))
    else $error("substitute remote flag misplaced");

  // [RL3] format bit placement
  a_ide_pack: assert property (@(posedge clk) disable iff (rst) // [RL3]
    ctl_wr |=> st_q.words[$past(ctl_buf)][0][EXT_FMT_POS]
               == $past(ctl_hdr.ext_fmt))
    else $error("format bit misplaced");

  // [RL5] extension high placement
  a_ext_pack: assert property (@(posedge clk) disable iff (rst) // [RL5]
    ctl_wr |=> st_q.words[$past(ctl_buf)][1]
               == {4'h0, $past(ctl_hdr.ext_id[17:6])})
    else $error("ext high misplaced");

  // [RL6] third word layout
  a_len_pack: assert property (@(posedge clk) disable iff (rst) // [RL6]
    ctl_wr |=> st_q.words[$past(ctl_buf)][2] ==
      {$past(ctl_hdr.ext_id[5:0]), $past(ctl_hdr.rtr), 5'h00,
       $past(ctl_hdr.dlc)})
    else $error("length word misplaced");

  // [RL6] unpacked view round trip
  // pack and unpack must agree, or the controller sends another frame
  a_round_trip: assert property (@(posedge clk) disable iff (rst) // [RL6]
    ctl_wr ##1 (ctl_buf == $past(ctl_buf)) |-> ctl_hdr_out == $past(ctl_hdr))
    else $error("unpacked header differs from the load");

  // storage invariant, buffer by buffer: bits with no field behind
  // them never hold a one, whichever side wrote the buffer last
  for (genvar g = 0; g < NUM_BUFS; g = g + 1) begin : g_clean
    // [RL4] unused and reserved clear
    a_store_clean: assert property (@(posedge clk) disable iff (rst) // [RL4]
      st_q.words[g][0][15:13] == 3'h0 && st_q.words[g][1][15:12] == 4'h0
      && st_q.words[g][2][8:4] == 5'h00)
      else $error("unused stored bits not clear");
  end
endmodule : msg_hdr_store
`default_nettype wire

/* File: tb/hdr_loader.sv */
// partner: controller side that loads decoded headers into buffers
`timescale 1ns/100ps
`default_nettype none
module hdr_loader
  import msg_hdr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               go,
  input  wire logic [4:0]         sel,
  input  wire msg_hdr_pkg::hdr_t  hdr,
  output logic                    ctl_wr,
  output logic [4:0]              ctl_buf,
  output var msg_hdr_pkg::hdr_t   ctl_hdr
);
  // whole header handed in one pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_wr  <= 1'b0;
      ctl_buf <= 5'h00;
      ctl_hdr <= '0;
    end else begin
      ctl_wr  <= go;
      ctl_buf <= sel; // also selects the unpacked view
      ctl_hdr <= go ? hdr : ~ctl_hdr; // no stale value between loads
    end
  end
endmodule : hdr_loader
`default_nettype wire

/* File: tb/tb_msg_hdr_store.sv */
// testbench: header store through register bus and controller port
`timescale 1ns/100ps
`default_nettype none
module tb_msg_hdr_store;
  import msg_hdr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        go  = 1'b0;
  logic        pv  = 1'b0;
  logic [4:0]  sel = 5'h00;
  logic [4:0]  cb;
  logic        cw;
  logic [31:0] rdata;
  logic [31:0] ex  = '0;
  logic [31:0] pe  = '0;
  bus_req_t    bus = '0;
  hdr_t        hdr = '0;
  hdr_t        ch;
  hdr_t        ho;
  hdr_t        h1  = {11'h5a3, 1'b1, 1'b0, 18'h2b3c5, 1'b1, 4'h8};
  logic [15:0] msk [4] = '{16'h1fff, 16'h0fff, 16'hfe0f, 16'h0000};
  int          n_fail = 0;
  int          samples_checked = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_fail++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
  msg_hdr_store msg_hdr_store_i (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .ctl_wr(cw), .ctl_buf(cb), .ctl_hdr(ch),
    .ctl_hdr_out(ho));
  hdr_loader hdr_loader_i (.clk(clk), .rst(rst), .go(go), .sel(sel),
    .hdr(hdr), .ctl_wr(cw), .ctl_buf(cb), .ctl_hdr(ch));
  initial forever #20 clk = ~clk;
  // expected word images built from the field layout
  function automatic logic [15:0] pk(hdr_t h, logic [1:0] w);
    case (w)
      2'h0: pk = {3'h0, h.base_id, h.sub_rr, h.ext_fmt};
      2'h1: pk = {4'h0, h.ext_id[17:6]};
      2'h2: pk = {h.ext_id[5:0], h.rtr, 5'h00, h.dlc};
      default: pk = 16'h0000;
    endcase
  endfunction : pk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    ex  <= {16'h0000, e};
    @(posedge clk);
  endtask : rd
  // read data is judged mid-cycle, where it stands for one cycle only
  always @(posedge clk) begin
    pv <= bus.rd;
    pe <= ex;
  end
  always @(negedge clk) if (!rst) `CHK(rdata, pv ? pe : 32'h0)
  task automatic results;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    #20000 n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(7'h00, 16'h0000);
    for (int w = 0; w < 4; w++) wr({5'h03, w[1:0]}, 16'hffff);
    for (int w = 0; w < 4; w++) rd({5'h03, w[1:0]}, msk[w]);
    bus <= '0;
    hdr <= h1;
    sel <= 5'h09;
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    repeat (2) @(posedge clk);
    for (int w = 0; w < 3; w++) rd({5'h09, w[1:0]}, pk(h1, w[1:0]));
    for (int w = 0; w < 3; w++) wr({5'h04, w[1:0]}, pk(~h1, w[1:0]));
    bus <= '0;
    sel <= 5'h04;
    repeat (2) @(posedge clk);
    @(negedge clk) `CHK(ho, ~h1)
    @(posedge clk);
    sel <= 5'h09;
    repeat (2) @(posedge clk);
    @(negedge clk) `CHK(ho, h1)
    results();
  end
endmodule : tb_msg_hdr_store
`default_nettype wire
